// [cpc_pkg.sv]
// package for the charge path controller: timing constants, setpoints and carriers
package cpc_pkg;
    localparam int    CLK_HZ          = 25_000_000;
    localparam int    QUAL_MS         = 32;
    localparam int    STABLE_MS       = 64;
    localparam int    ALERT_US        = 256;
    localparam int    TERM_DGL_MS     = 200;
    localparam int    OVP_PERSIST_MS  = 10;
    localparam longint PRE_LIMIT_S    = 3600;
    localparam int    QUAL_CYC        = QUAL_MS * (CLK_HZ / 1000);
    localparam int    STABLE_CYC      = STABLE_MS * (CLK_HZ / 1000);
    localparam int    ALERT_CYC       = ALERT_US * (CLK_HZ / 1_000_000);
    localparam int    TERM_DGL_CYC    = TERM_DGL_MS * (CLK_HZ / 1000);
    localparam int    OVP_PERSIST_CYC = OVP_PERSIST_MS * (CLK_HZ / 1000);
    localparam longint PRE_LIMIT_CYC  = PRE_LIMIT_S * CLK_HZ;
    localparam int    WDT_S           = 160;
    localparam longint WDT_CYC        = WDT_S * CLK_HZ;
    localparam int    RECYCLE_MS      = 100;
    localparam int    RECYCLE_CYC     = RECYCLE_MS * (CLK_HZ / 1000);
    localparam logic [1:0] TMO_FORCED = 2'h1;
    localparam logic [1:0] TMO_OFF    = 2'h0;

    // analog comparator results, from the analog front end (asynchronous)
    typedef struct packed {
        logic in_uv;
        logic in_ov;
        logic headroom_ok;
        logic bat_below_pre;
        logic bat_at_reg;
        logic ichg_le_term;
        logic bat_ovp;
        logic bat_recharge;
        logic ntc_fault;
    } cpc_sense_t;

    // host-written settings, on the link clock
    typedef struct packed {
        logic       input_path_off;
        logic       charge_disable;
        logic       term_detect_en;
        logic       safety_tmr_en;
        logic       term_hold_off;
        logic       cc_quarter_scale;
        logic [3:0] sys_voltage_setpoint;
        logic [3:0] term_current_sel;
        logic [5:0] cc_current_sel;
        logic [5:0] cv_voltage_sel;
        logic [1:0] host_timeout_sel;
    } cpc_cfg_t;

    // drive to the analog loops
    typedef struct packed {
        logic       input_switch_on;
        logic       rvs_switch_on;
        logic       bat_charge_on;
        logic       bat_discharge_on;
        logic       sys_out_on;
        logic [3:0] sys_setpoint;
        logic [5:0] i_setpoint;
        logic       i_quarter;
        logic [5:0] v_setpoint;
    } cpc_drive_t;
endpackage

// [cpc_top.sv]
// charge path controller: input qualification, charge phases, host timeout
//
// Contract
// RQ1 - connect input only after it stays in range for the qualification interval
// RQ2 - input under or over voltage turns input and reverse switches off at once
// RQ3 - input state stable for stability interval gives one low alert pulse
// RQ4 - valid input and each alert force timeout select to 01; host write restores
// RQ5 - host restarts enabled timeout by writing; expiry resets and recycles system
// RQ6 - recycle system power on timeout, ignored input alert, or recycle request
// RQ7 - conduct input with headroom, regulate system to selected setpoint
// RQ8 - input_path_off set turns input switch off; cleared has no effect
// RQ9 - charge_disable blocks charging direction only, discharge unaffected
// RQ10 - below pre-charge threshold charge at termination-selected current
// RQ11 - constant current from cc_current_sel, quartered when scale bit set
// RQ12 - at regulation voltage hold voltage at cv_voltage_sel
// RQ13 - with detection on, current at or below term for deglitch ends cycle
// RQ14 - with safety timer on, timer expiry also ends the cycle
// RQ15 - termination reports complete; cuts current only when hold-off bit clear
// RQ16 - new cycle on input cycle, enable or recharge, only with no faults
// RQ17 - battery over-voltage suspends charging at once and flags a fault
// RQ18 - persisting battery over-voltage turns on the discharge path
// RQ19 - host link and alert stay alive while input or battery is present
// RQ20 - pre-charge limited to one hour, safety fault on expiry
// RQ21 - intervals are counters restarting when the condition breaks
`timescale 1ns/1ps
module cpc_top
    import cpc_pkg::*;
#(
    parameter int     QUAL_N     = QUAL_CYC,
    parameter int     STABLE_N   = STABLE_CYC,
    parameter int     TERM_N     = TERM_DGL_CYC,
    parameter int     OVP_N      = OVP_PERSIST_CYC,
    parameter int     RECYCLE_N  = RECYCLE_CYC,
    parameter longint PRE_N      = PRE_LIMIT_CYC,
    parameter longint SAFETY_N   = PRE_LIMIT_CYC,
    parameter longint WDT_N      = WDT_CYC
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    input  wire logic              LINK_CLK,
    input  wire logic              LINK_RST_N,
    input  wire cpc_pkg::cpc_sense_t SENSE,
    input  wire logic              SUPPLY_PRESENT,
    input  wire cpc_pkg::cpc_cfg_t HOST_CFG,
    input  wire logic              HOST_WR,
    input  wire logic              HOST_CHG_EN,
    input  wire logic              HOST_RECYCLE_REQ,
    output cpc_pkg::cpc_drive_t    DRIVE,
    output logic                   HOST_ALERT_N,
    output logic [1:0]             TIMEOUT_SEL,
    output logic                   CHARGE_DONE,
    output logic                   BAT_FAULT,
    output logic                   TIMER_FAULT,
    output logic                   DEVICE_RESET
);
    import cpc_pkg::*;

    if (QUAL_N < 1 || STABLE_N < 1 || TERM_N < 1 || OVP_N < 1 || RECYCLE_N < 1 || ALERT_CYC < 1
        || PRE_N < 1 || SAFETY_N < 1 || WDT_N < 1) begin : g_bad_count
        $error("cpc_top: interval counts must be at least one cycle");
    end

    typedef enum logic [4:0] {
        CH_IDLE = 5'h01,
        CH_PRE  = 5'h02,
        CH_CC   = 5'h04,
        CH_CV   = 5'h08,
        CH_DONE = 5'h10
    } cpc_phase_t;

    // ---------------- link domain: host settings and timeout select ----------
    cpc_cfg_t   cfg_l;
    logic [1:0] saved_sel;
    logic       forced;
    logic       wr_tog;
    logic       chg_tog;
    logic       rcy_tog;
    logic       force_tog;
    logic       cfg_tog;
    logic [2:0] force_sync;
    logic       force_seen;

    // the force arrives as a toggle; the link clock may stop outside frames,
    // so it is acted on at the link edge after it is synchronized, unless a host write takes that edge.
    always_ff @(posedge LINK_CLK or negedge LINK_RST_N) begin
        if (!LINK_RST_N) begin
            force_sync <= 3'h0;
        end else begin
            force_sync <= {force_sync[1:0], force_tog};
        end
    end
    assign force_seen = force_sync[2] ^ force_sync[1];

    always_ff @(posedge LINK_CLK or negedge LINK_RST_N) begin
        if (!LINK_RST_N) begin
            cfg_l     <= '0;
            saved_sel <= TMO_OFF;
            forced    <= 1'b0;
        end else if (HOST_WR) begin
            cfg_l <= HOST_CFG;
            if (forced) begin
                cfg_l.host_timeout_sel <= saved_sel; // RQ4
            end
            forced <= 1'b0;
        end else if (force_seen) begin
            if (!forced) begin
                saved_sel <= cfg_l.host_timeout_sel;
            end
            cfg_l.host_timeout_sel <= TMO_FORCED; // RQ4
            forced <= 1'b1;
        end
    end

    always_ff @(posedge LINK_CLK or negedge LINK_RST_N) begin
        if (!LINK_RST_N) begin
            wr_tog  <= 1'b0;
            chg_tog <= 1'b0;
            rcy_tog <= 1'b0;
            cfg_tog <= 1'b0;
        end else begin
            if (HOST_WR) begin
                wr_tog <= ~wr_tog; // RQ5
            end
            // any change of cfg_l is announced, so the main side never samples it moving
            if (HOST_WR || force_seen) begin
                cfg_tog <= ~cfg_tog;
            end
            if (HOST_CHG_EN) begin
                chg_tog <= ~chg_tog;
            end
            if (HOST_RECYCLE_REQ) begin
                rcy_tog <= ~rcy_tog;
            end
        end
    end

    // ---------------- crossing into REF_CLK ----------------------------------
    // cfg_l holds still for several cycles after its toggle, so it is taken whole
    logic [2:0] cfg_s;
    cpc_cfg_t   cfg;
    cpc_sense_t sn_s1;
    cpc_sense_t sn;
    logic [2:0] wr_s;
    logic [2:0] chg_s;
    logic [2:0] rcy_s;
    logic [1:0] sup_s;

    // input counts as absent until sensed, so reset gives no false input change
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_s  <= 3'h0;
            cfg    <= '0;
            sn_s1  <= '{in_uv: 1'b1, default: 1'b0};
            sn     <= '{in_uv: 1'b1, default: 1'b0};
            wr_s   <= 3'h0;
            chg_s  <= 3'h0;
            rcy_s  <= 3'h0;
            sup_s  <= 2'h0;
        end else begin
            cfg_s  <= {cfg_s[1:0], cfg_tog};
            if (cfg_s[2] ^ cfg_s[1]) begin
                cfg <= cfg_l;
            end
            sn_s1  <= SENSE;
            sn     <= sn_s1;
            sup_s  <= {sup_s[0], SUPPLY_PRESENT};
            wr_s   <= {wr_s[1:0], wr_tog};
            chg_s  <= {chg_s[1:0], chg_tog};
            rcy_s  <= {rcy_s[1:0], rcy_tog};
        end
    end

    logic host_wr_p;
    logic chg_en_p;
    logic rcy_p;
    assign host_wr_p = wr_s[2] ^ wr_s[1];
    assign chg_en_p  = chg_s[2] ^ chg_s[1];
    assign rcy_p     = rcy_s[2] ^ rcy_s[1];

    // ---------------- input qualification and alert -------------------------
    logic        in_ok;
    logic        in_valid;
    logic        in_state;
    logic [31:0] qual_cnt;
    logic [31:0] stab_cnt;
    logic [31:0] alert_cnt;
    logic        reported;
    logic        alert_start;
    assign in_ok = !sn.in_uv && !sn.in_ov;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            qual_cnt <= 32'h0;
            in_valid <= 1'b0;
        end else if (!in_ok) begin
            qual_cnt <= 32'h0; // RQ21
            in_valid <= 1'b0;  // RQ2
        end else if (!in_valid) begin
            if (qual_cnt == 32'(QUAL_N - 1)) begin
                in_valid <= 1'b1; // RQ1
            end else begin
                qual_cnt <= qual_cnt + 32'h1;
            end
        end
    end

    assign alert_start = !reported && stab_cnt == 32'(STABLE_N - 1);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_state <= 1'b0;
            stab_cnt <= 32'h0;
            reported <= 1'b1;
        end else if (in_ok != in_state) begin
            in_state <= in_ok;
            stab_cnt <= 32'h0; // RQ21
            reported <= 1'b0;
        end else if (!reported) begin
            stab_cnt <= stab_cnt + 32'h1;
            if (alert_start) begin
                reported <= 1'b1; // RQ3
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            alert_cnt    <= 32'h0;
            HOST_ALERT_N <= 1'b1;
        end else if (alert_start) begin
            alert_cnt    <= 32'(ALERT_CYC - 1);
            HOST_ALERT_N <= 1'b0; // RQ3
        end else if (alert_cnt != 32'h0) begin
            alert_cnt <= alert_cnt - 32'h1;
        end else begin
            HOST_ALERT_N <= 1'b1;
        end
    end

    // force request toggles on valid input rising and on each alert
    logic in_valid_d;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_valid_d <= 1'b0;
            force_tog  <= 1'b0;
        end else begin
            in_valid_d <= in_valid;
            if ((in_valid && !in_valid_d) || alert_start) begin
                force_tog <= ~force_tog; // RQ4
            end
        end
    end

    // ---------------- host timeout and system recycle ------------------------
    logic [63:0] wdt_cnt;
    logic [31:0] rcy_cnt;
    logic        wdt_expire;
    logic        in_cycle_p;
    assign wdt_expire = cfg.host_timeout_sel != TMO_OFF && wdt_cnt == 64'(WDT_N - 1);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wdt_cnt <= 64'h0;
        end else if (cfg.host_timeout_sel == TMO_OFF || host_wr_p || wdt_expire) begin
            wdt_cnt <= 64'h0; // RQ5
        end else begin
            wdt_cnt <= wdt_cnt + 64'h1;
        end
    end

    // forced timeout with no host answer ends in the same expiry
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rcy_cnt      <= 32'h0;
            DEVICE_RESET <= 1'b0;
        end else if (wdt_expire || rcy_p) begin
            rcy_cnt      <= 32'(RECYCLE_N); // RQ6
            DEVICE_RESET <= wdt_expire;     // RQ5
        end else if (rcy_cnt != 32'h0) begin
            rcy_cnt      <= rcy_cnt - 32'h1;
            DEVICE_RESET <= 1'b0;
        end
    end

    // ---------------- charge phases ------------------------------------------
    cpc_phase_t  phase;
    logic [31:0] term_cnt;
    logic [31:0] ovp_cnt;
    logic [63:0] safe_cnt;
    logic        term_hit;
    logic        safe_hit;
    logic        can_start;
    logic        recharge_p;
    logic        recharge_d;
    assign in_cycle_p = in_valid && !in_valid_d;
    assign recharge_p = sn.bat_recharge && !recharge_d;
    assign can_start  = !sn.ntc_fault && !TIMER_FAULT && !sn.bat_ovp && !cfg.charge_disable; // RQ16
    assign term_hit   = cfg.term_detect_en && term_cnt == 32'(TERM_N - 1);
    assign safe_hit   = (phase == CH_PRE) ? (safe_cnt == 64'(PRE_N - 1))
                                          : (cfg.safety_tmr_en && safe_cnt == 64'(SAFETY_N - 1));

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            term_cnt <= 32'h0;
        end else if (!sn.ichg_le_term || !(phase == CH_CV)) begin
            term_cnt <= 32'h0; // RQ21
        end else if (term_cnt != 32'(TERM_N - 1)) begin
            term_cnt <= term_cnt + 32'h1; // RQ13
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            safe_cnt <= 64'h0;
        end else if (phase == CH_IDLE || phase == CH_DONE || (phase == CH_PRE && !sn.bat_below_pre)) begin
            safe_cnt <= 64'h0;
        end else if (!safe_hit) begin
            safe_cnt <= safe_cnt + 64'h1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase       <= CH_IDLE;
            recharge_d  <= 1'b0;
            CHARGE_DONE <= 1'b0;
            TIMER_FAULT <= 1'b0;
        end else begin
            recharge_d <= sn.bat_recharge;
            // cleared first so a fault raised in the same cycle wins
            if (chg_en_p) begin
                TIMER_FAULT <= 1'b0;
            end
            if (!in_valid) begin
                phase <= CH_IDLE;
            end else begin
                case (phase)
                    CH_IDLE, CH_DONE: begin
                        if ((in_cycle_p || chg_en_p || recharge_p) && can_start) begin
                            phase       <= CH_PRE; // RQ16
                            CHARGE_DONE <= 1'b0;
                        end
                    end
                    CH_PRE: begin
                        if (safe_hit) begin
                            TIMER_FAULT <= 1'b1; // RQ20
                            phase       <= CH_IDLE;
                        end else if (!sn.bat_below_pre) begin
                            phase <= CH_CC;
                        end
                    end
                    CH_CC: begin
                        if (safe_hit) begin
                            CHARGE_DONE <= 1'b1; // RQ14
                            phase       <= CH_DONE;
                        end else if (sn.bat_at_reg) begin
                            phase <= CH_CV;
                        end
                    end
                    CH_CV: begin
                        if (term_hit || safe_hit) begin
                            CHARGE_DONE <= 1'b1; // RQ15
                            if (!cfg.term_hold_off || safe_hit) begin
                                phase <= CH_DONE; // RQ13
                            end
                        end
                    end
                    default: phase <= CH_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovp_cnt   <= 32'h0;
            BAT_FAULT <= 1'b0;
        end else if (!sn.bat_ovp) begin
            ovp_cnt   <= 32'h0;
            BAT_FAULT <= 1'b0;
        end else begin
            BAT_FAULT <= 1'b1; // RQ17
            if (ovp_cnt != 32'(OVP_N)) begin
                ovp_cnt <= ovp_cnt + 32'h1;
            end
        end
    end

    // ---------------- switch and setpoint drive ------------------------------
    // RQ19: host link and alert run on the always-on rail, gated only by reset
    logic charging;
    assign charging = (phase == CH_PRE || phase == CH_CC || phase == CH_CV) && !sn.bat_ovp;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DRIVE       <= '0;
            TIMEOUT_SEL <= TMO_OFF;
        end else begin
            TIMEOUT_SEL            <= cfg.host_timeout_sel;
            DRIVE.input_switch_on  <= in_valid && in_ok && sn.headroom_ok && !cfg.input_path_off
                                      && rcy_cnt == 32'h0 && sup_s[1]; // RQ7 RQ8
            DRIVE.rvs_switch_on    <= in_valid && in_ok && rcy_cnt == 32'h0; // RQ2
            DRIVE.bat_charge_on    <= charging && !cfg.charge_disable; // RQ9 RQ17
            DRIVE.bat_discharge_on <= ovp_cnt == 32'(OVP_N) || !in_valid || rcy_cnt == 32'h0; // RQ18
            DRIVE.sys_out_on       <= rcy_cnt == 32'h0; // RQ6
            DRIVE.sys_setpoint     <= cfg.sys_voltage_setpoint; // RQ7
            DRIVE.i_setpoint       <= (phase == CH_PRE) ? {2'h0, cfg.term_current_sel} // RQ10
                                                        : cfg.cc_current_sel; // RQ11
            DRIVE.i_quarter        <= phase != CH_PRE && cfg.cc_quarter_scale; // RQ11
            DRIVE.v_setpoint       <= cfg.cv_voltage_sel; // RQ12
        end
    end

    // ---------------- assertions ---------------------------------------------
    property p_uv_off;
        @(posedge REF_CLK) disable iff (!RST_N) !in_ok |=> !in_valid;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("input not dropped on fault"); // RQ2

    property p_valid_needs_qual;
        @(posedge REF_CLK) disable iff (!RST_N) $rose(in_valid) |-> qual_cnt == 32'(QUAL_N - 1);
    endproperty
    a_valid_needs_qual: assert property (p_valid_needs_qual) else $error("input valid early"); // RQ1

    sequence s_alert_go;
        alert_start;
    endsequence
    property p_alert_pulse;
        @(posedge REF_CLK) disable iff (!RST_N) s_alert_go |=> !HOST_ALERT_N;
    endproperty
    a_alert_pulse: assert property (p_alert_pulse) else $error("alert pulse missing"); // RQ3

    property p_charge_block;
        @(posedge REF_CLK) disable iff (!RST_N) cfg.charge_disable |=> !DRIVE.bat_charge_on;
    endproperty
    a_charge_block: assert property (p_charge_block) else $error("charge not blocked"); // RQ9

    property p_hiz;
        @(posedge REF_CLK) disable iff (!RST_N) cfg.input_path_off |=> !DRIVE.input_switch_on;
    endproperty
    a_hiz: assert property (p_hiz) else $error("input path not off"); // RQ8

    property p_ovp;
        @(posedge REF_CLK) disable iff (!RST_N) sn.bat_ovp |=> BAT_FAULT && !DRIVE.bat_charge_on;
    endproperty
    a_ovp: assert property (p_ovp) else $error("over-voltage not handled"); // RQ17

    property p_pre_current;
        @(posedge REF_CLK) disable iff (!RST_N) phase == CH_PRE |=> DRIVE.i_setpoint[3:0] == $past(cfg.term_current_sel);
    endproperty
    a_pre_current: assert property (p_pre_current) else $error("pre-charge current wrong"); // RQ10

    property p_wdt_recycle;
        @(posedge REF_CLK) disable iff (!RST_N) wdt_expire |=> DEVICE_RESET ##1 !DRIVE.sys_out_on;
    endproperty
    a_wdt_recycle: assert property (p_wdt_recycle) else $error("timeout did not recycle"); // RQ5
endmodule // cpc_top

// [cpc_host_model.sv]
// host model: link-side command pulses and regular timeout restarts
`timescale 1ns/1ps
module cpc_host_model (
    input  wire logic       link_clk,
    input  wire logic       link_rst_n,
    input  wire logic [1:0] timeout_sel,
    input  wire logic       mute,
    input  wire logic [2:0] cmd,
    output logic            wr,
    output logic            chg_en,
    output logic            recycle
);
    logic [2:0] prev;
    logic [3:0] cnt;
    // a rising bench command gives one link-cycle pulse
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            prev    <= 3'h0;
            cnt     <= 4'h0;
            wr      <= 1'b0;
            chg_en  <= 1'b0;
            recycle <= 1'b0;
        end else begin
            prev    <= cmd;
            cnt     <= cnt + 4'h1;
            // restarts every 16 link cycles, well over the crossing spacing
            wr      <= (cmd[0] & ~prev[0]) | (~mute & (timeout_sel != 2'h0) & (cnt == 4'h0));
            chg_en  <= cmd[1] & ~prev[1];
            recycle <= cmd[2] & ~prev[2];
        end
    end
endmodule // cpc_host_model

// [testbench.sv]
// testbench for the charge path controller
`timescale 1ns/1ps
module testbench;
    import cpc_pkg::*;
    localparam int QN = 8, SN = 50, TN = 6, ON = 5, RN = 6;
    logic       REF_CLK = 1'b0, LINK_CLK = 1'b0, RST_N = 1'b0, mute = 1'b1;
    logic [2:0] cmd = 3'h0;
    cpc_sense_t sense;
    cpc_cfg_t   cfg;
    cpc_drive_t drv;
    logic       wr, chg, rcy, alert_n, done, bfault, tfault, dreset;
    logic [1:0] tsel;
    int         fails = 0, checks = 0, n, cyc_cnt = 0;

    always #20 REF_CLK = ~REF_CLK;
    // link clock offset so its edges never line up with the main clock
    initial begin
        #3.1;
        forever #7.5 LINK_CLK = ~LINK_CLK;
    end

    cpc_top #(.QUAL_N(QN), .STABLE_N(SN), .TERM_N(TN), .OVP_N(ON), .RECYCLE_N(RN),
        .PRE_N(300), .SAFETY_N(20000), .WDT_N(50)) dut_u (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .LINK_RST_N(RST_N),
        .SENSE(sense), .SUPPLY_PRESENT(1'b1), .HOST_CFG(cfg), .HOST_WR(wr),
        .HOST_CHG_EN(chg), .HOST_RECYCLE_REQ(rcy), .DRIVE(drv), .HOST_ALERT_N(alert_n),
        .TIMEOUT_SEL(tsel), .CHARGE_DONE(done), .BAT_FAULT(bfault), .TIMER_FAULT(tfault),
        .DEVICE_RESET(dreset));

    cpc_host_model host_u (.link_clk(LINK_CLK), .link_rst_n(RST_N), .timeout_sel(tsel),
        .mute(mute), .cmd(cmd), .wr(wr), .chg_en(chg), .recycle(rcy));

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(int k);
        repeat (k) @(negedge REF_CLK);
    endtask

    task automatic send(int b);
        cmd[b] = 1'b1;
        cyc(8);
        cmd[b] = 1'b0;
        cyc(8);
    endtask

    task results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge REF_CLK) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fails++;
            results();
        end
    end

    initial begin
        sense = '0;
        sense.in_uv = 1'b1;
        sense.bat_below_pre = 1'b1;
        cfg = '0;
        cfg.sys_voltage_setpoint = 4'h5;
        cfg.term_current_sel = 4'h3;
        cfg.cc_current_sel = 6'h2a;
        cfg.cv_voltage_sel = 6'h15;
        cfg.cc_quarter_scale = 1'b1;
        cfg.term_detect_en = 1'b1;
        cyc(6);
        RST_N = 1'b1;
        cyc(4);
        chk("alert_idle", alert_n, 1);
        chk("in_sw_reset", drv.input_switch_on, 0);
        send(0);
        sense.in_uv = 1'b0;
        sense.headroom_ok = 1'b1;
        cyc(5);
        // short dip must restart qualification
        sense.in_uv = 1'b1;
        cyc(1);
        sense.in_uv = 1'b0;
        n = 0;
        while (drv.input_switch_on !== 1'b1 && n < 40) begin cyc(1); n++; end
        chk("qual_time", 16'(n >= QN && n < 40), 1);
        cyc(2);
        chk("rvs_on", drv.rvs_switch_on, 1);
        chk("sys_set", drv.sys_setpoint, 4'h5);
        chk("pre_i", drv.i_setpoint, 6'h03);
        chk("chg_on", drv.bat_charge_on, 1);
        n = 0;
        while (tsel !== TMO_FORCED && n < 20) begin cyc(1); n++; end
        chk("tsel_forced", tsel, TMO_FORCED);
        mute = 1'b0;
        cyc(20);
        chk("tsel_back", tsel, TMO_OFF);
        sense.bat_below_pre = 1'b0;
        n = 0;
        while (alert_n !== 1'b0 && n < SN + 10) begin cyc(1); n++; end
        n = 0;
        while (alert_n === 1'b0 && n < 7000) begin cyc(1); n++; end
        chk("alert_width", 16'(n), 16'(ALERT_CYC));
        cyc(8);
        chk("cc_i", drv.i_setpoint, 6'h2a);
        chk("cc_quarter", drv.i_quarter, 1);
        chk("cv_v", drv.v_setpoint, 6'h15);
        sense.bat_at_reg = 1'b1;
        sense.ichg_le_term = 1'b1;
        cyc(TN / 2);
        chk("done_early", done, 0);
        cyc(TN + 6);
        chk("done", done, 1);
        chk("term_cut", drv.bat_charge_on, 0);
        sense.bat_at_reg = 1'b0;
        sense.ichg_le_term = 1'b0;
        cfg.charge_disable = 1'b1;
        send(0);
        send(1);
        chk("refused", drv.bat_charge_on, 0);
        chk("dis_kept", drv.bat_discharge_on, 1);
        cfg.charge_disable = 1'b0;
        send(0);
        send(1);
        chk("restart", drv.bat_charge_on, 1);
        sense.bat_ovp = 1'b1;
        cyc(4);
        chk("ovp_cut", drv.bat_charge_on, 0);
        chk("ovp_fault", bfault, 1);
        cyc(ON + 6);
        chk("ovp_dis", drv.bat_discharge_on, 1);
        sense.bat_ovp = 1'b0;
        cfg.input_path_off = 1'b1;
        send(0);
        chk("path_off", drv.input_switch_on, 0);
        cfg.input_path_off = 1'b0;
        send(0);
        cmd[2] = 1'b1;
        n = 0;
        while (drv.sys_out_on !== 1'b0 && n < 20) begin cyc(1); n++; end
        cmd[2] = 1'b0;
        chk("rcy_off", drv.sys_out_on, 0);
        n = 0;
        while (drv.sys_out_on !== 1'b1 && n < RN + 20) begin cyc(1); n++; end
        chk("rcy_len", 16'(n >= RN - 1 && n <= RN + 1), 1);
        sense.in_uv = 1'b1;
        cyc(4);
        chk("uv_in_off", drv.input_switch_on, 0);
        chk("uv_rvs_off", drv.rvs_switch_on, 0);
        // silent host: forced timeout must expire and reset
        mute = 1'b1;
        sense.bat_below_pre = 1'b1;
        sense.in_uv = 1'b0;
        n = 0;
        while (dreset !== 1'b1 && n < 400) begin cyc(1); n++; end
        chk("wdt_reset", dreset, 1);
        // battery stuck below pre-charge threshold: limit must trip later
        chk("pre_early", tfault, 0);
        n = 0;
        while (tfault !== 1'b1 && n < 400) begin cyc(1); n++; end
        chk("pre_limit", tfault, 1);
        cyc(2);
        chk("pre_stop", drv.bat_charge_on, 0);
        results();
    end
endmodule // testbench
